// ---- design/phy_end_ctrl.sv ----
// phy end of the mac data link: receive toward mac, transmit from mac
`timescale 1ns/1ns
`default_nettype none
module phy_end_ctrl
  import mac_phy_pkg::*;
#(
  parameter int BUF_DEPTH = 2
)
(
  mac_phy_if.phy_end   link,
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic [2:0] cfg_mode_strap,
  input  wire logic       speed_10,
  input  wire logic       full_duplex,
  input  wire logic       med_carrier,
  input  wire logic       med_false_carrier,
  input  wire logic       med_symbol_err,
  input  wire logic       med_collision,
  input  wire logic       rx_valid,
  input  wire logic [3:0] rx_nib,
  output logic            rx_ready,
  output logic            tx_valid,
  output logic [3:0]      tx_nib,
  output logic            tx_last
);

  if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two of at least 2");
  end

  localparam int AW = $clog2(BUF_DEPTH);

  ifc_mode_t  mode_ff;
  logic       strap_done_ff;
  logic       is_rmii;
  logic       is_mii;
  logic       is_serial;

  // mode latched once after reset release
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_ff       <= MODE_AT_RESET;
      strap_done_ff <= 1'b0;
    end
    else if (!strap_done_ff)
    begin
      strap_done_ff <= 1'b1;
      unique case (cfg_mode_strap)
        ifc_rmii,
        ifc_mii,
        ifc_serial: mode_ff <= ifc_mode_t'(cfg_mode_strap);
        default:    mode_ff <= MODE_AT_RESET;
      endcase
    end
  end

  assign is_rmii   = (mode_ff == ifc_rmii);
  assign is_mii    = (mode_ff == ifc_mii);
  assign is_serial = (mode_ff == ifc_serial);

  // link inputs: two-stage synchroniser
  logic [6:0] in_s1_ff;
  logic [6:0] in_s2_ff;
  logic       ref_prev_ff;
  logic       txc_prev_ff;
  logic       en_s;
  logic [3:0] txd_s;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      in_s1_ff    <= 7'h00;
      in_s2_ff    <= 7'h00;
      ref_prev_ff <= 1'b0;
      txc_prev_ff <= 1'b0;
    end
    else
    begin
      in_s1_ff    <= {link.ref_clk, link.tx_clk, link.tx_en, link.txd};
      in_s2_ff    <= in_s1_ff;
      ref_prev_ff <= in_s2_ff[6];
      txc_prev_ff <= in_s2_ff[5];
    end
  end

  assign en_s  = in_s2_ff[4];
  assign txd_s = in_s2_ff[3:0];

  // receive clock made here from mclk
  logic [5:0] rxdiv_ff;
  logic       rx_clk_ff;
  logic       rx_flip;
  logic       rx_fall;

  assign rx_flip = !is_rmii && (rxdiv_ff >= clk_half(mode_ff, speed_10) - 6'h01);
  assign rx_fall = rx_flip && rx_clk_ff;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxdiv_ff  <= 6'h00;
      rx_clk_ff <= 1'b0;
    end
    else if (rx_flip)
    begin
      rxdiv_ff  <= 6'h00;
      rx_clk_ff <= !rx_clk_ff;
    end
    else if (!is_rmii)
    begin
      rxdiv_ff <= rxdiv_ff + 6'h01;
    end
  end

  // receive buffer between user and link
  logic [3:0]    buf_mem [BUF_DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   cnt_ff;
  logic          has_data;
  logic          push;
  logic          pop;
  logic [3:0]    head;
  logic [1:0]    ser_left_ff;

  assign rx_ready = (cnt_ff != (AW+1)'(BUF_DEPTH));
  assign push     = rx_valid && rx_ready;
  assign has_data = (cnt_ff != '0);
  assign head     = buf_mem[rd_ptr_ff];
  assign pop      = rx_fall && has_data
                    && ((is_mii && !med_false_carrier)
                    || (is_serial && ser_left_ff == 2'h0));

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      buf_mem[wr_ptr_ff] <= rx_nib;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else
    begin
      wr_ptr_ff <= wr_ptr_ff + AW'(push);
      rd_ptr_ff <= rd_ptr_ff + AW'(pop);
      cnt_ff    <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // receive side outputs
  logic       rx_dv_ff;
  logic       rx_er_ff;
  logic       rx_busy_ff;
  logic [3:0] rxd_ff;
  logic [3:0] ser_ff;
  logic       sym_ff;
  logic       col_ff;

  // symbol error marks the packet from the error until carrier ends; set wins over carrier end
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sym_ff <= 1'b0;
    end
    else
    begin
      sym_ff <= med_symbol_err || (sym_ff && med_carrier);
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_dv_ff    <= 1'b0;
      rx_er_ff    <= 1'b0;
      rx_busy_ff  <= 1'b0;
      rxd_ff      <= 4'h0;
      ser_ff      <= 4'h0;
      ser_left_ff <= 2'h0;
    end
    else if (rx_fall)
    begin
      rx_dv_ff   <= 1'b0;
      rx_er_ff   <= 1'b0;
      rx_busy_ff <= 1'b0;
      rxd_ff     <= 4'h0;
      unique case (mode_ff)
        ifc_mii:
        begin
          if (med_false_carrier)
          begin
            rxd_ff   <= FALSE_CARRIER_CODE;
            rx_er_ff <= !speed_10;
          end
          else if (has_data)
          begin
            rx_dv_ff   <= 1'b1;
            rx_busy_ff <= 1'b1;
            rxd_ff     <= (sym_ff && !speed_10) ? SYMBOL_ERR_CODE : head;
          end
        end
        ifc_serial:
        begin
          if (ser_left_ff != 2'h0)
          begin
            rx_busy_ff  <= 1'b1;
            rxd_ff      <= {3'h0, ser_ff[0]};
            ser_ff      <= {1'b0, ser_ff[3:1]};
            ser_left_ff <= ser_left_ff - 2'h1;
          end
          else if (has_data)
          begin
            rx_busy_ff  <= 1'b1;
            rxd_ff      <= {3'h0, head[0]};
            ser_ff      <= {1'b0, head[3:1]};
            ser_left_ff <= 2'h3;
          end
        end
        ifc_rmii:
        begin
          ser_left_ff <= 2'h0;
        end
      endcase
    end
  end

  // collision only in half duplex
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      col_ff <= 1'b0;
    end
    else
    begin
      col_ff <= !is_rmii && med_collision && !full_duplex;
    end
  end

  // outside rmii, carrier follows the medium without waiting for a clock; in rmii it stays low
  // serial framing starts at the first bit shown, so queued data alone raises carrier only on mii
  assign link.crs    = !is_rmii
                       && (med_carrier || rx_busy_ff || (is_mii && has_data));
  assign link.rx_clk = rx_clk_ff;
  assign link.rx_dv  = rx_dv_ff;
  assign link.rx_er  = rx_er_ff;
  assign link.rxd    = rxd_ff;
  assign link.col    = col_ff;

  // transmit side: sample on the sampled rising edge of the source clock
  logic       tx_edge;
  logic       rmii10;
  logic       take;
  logic [3:0] acc_ff;
  logic [2:0] have_ff;
  logic [3:0] rep_ff;
  logic       in_frame_ff;
  logic       sfd_seen_ff;
  logic       tx_valid_ff;
  logic       tx_last_ff;
  logic [3:0] tx_nib_ff;
  logic [3:0] nxt_acc;
  logic [2:0] nxt_have;

  assign tx_edge = is_rmii ? (in_s2_ff[6] && !ref_prev_ff)
                           : (in_s2_ff[5] && !txc_prev_ff);
  assign rmii10  = is_rmii && speed_10;
  assign take    = tx_edge && en_s && (!rmii10 || rep_ff == 4'h0);

  always_comb
  begin
    nxt_have = have_ff + unit_bits(mode_ff);
    unique case (mode_ff)
      ifc_rmii:   nxt_acc = {txd_s[1:0], acc_ff[3:2]};
      ifc_serial: nxt_acc = {txd_s[0], acc_ff[3:1]};
      ifc_mii:    nxt_acc = txd_s;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      acc_ff      <= 4'h0;
      have_ff     <= 3'h0;
      rep_ff      <= 4'h0;
      in_frame_ff <= 1'b0;
      sfd_seen_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_last_ff  <= 1'b0;
      tx_nib_ff   <= 4'h0;
    end
    else
    begin
      tx_valid_ff <= 1'b0;
      tx_last_ff  <= 1'b0;
      if (tx_edge && !en_s)
      begin
        // partial nibble is discarded here
        tx_last_ff  <= in_frame_ff;
        in_frame_ff <= 1'b0;
        have_ff     <= 3'h0;
        rep_ff      <= 4'h0;
        sfd_seen_ff <= 1'b0;
      end
      else if (tx_edge)
      begin
        in_frame_ff <= 1'b1;
        rep_ff      <= (rep_ff == RMII10_REPEAT - 4'h1) ? 4'h0 : rep_ff + 4'h1;
      end
      if (take)
      begin
        if (rmii10 && !sfd_seen_ff && txd_s[1:0] == SFD_LAST_DIBIT)
        begin
          tx_valid_ff <= 1'b1;
          tx_nib_ff   <= SFD_NIBBLE;
          have_ff     <= 3'h0;
          sfd_seen_ff <= 1'b1;
        end
        else if (nxt_have == 3'h4)
        begin
          tx_valid_ff <= 1'b1;
          tx_nib_ff   <= nxt_acc;
          have_ff     <= 3'h0;
        end
        else
        begin
          have_ff <= nxt_have;
          acc_ff  <= nxt_acc;
        end
      end
    end
  end

  assign tx_valid = tx_valid_ff;
  assign tx_nib   = tx_nib_ff;
  assign tx_last  = tx_last_ff;

endmodule : phy_end_ctrl
`default_nettype wire

// ---- design/mac_phy_pkg.sv ----
// shared constants, modes and helpers for both ends of the mac/phy link
package mac_phy_pkg;

  typedef enum logic [2:0]
  {
    ifc_rmii   = 3'b001,
    ifc_mii    = 3'b010,
    ifc_serial = 3'b100
  } ifc_mode_t;

  // periods in ns, half periods in mclk cycles
  localparam int        CLK_NS      = 10;
  localparam int        REF_NS      = 20;
  localparam int        MII100_NS   = 40;
  localparam int        MII10_NS    = 400;
  localparam int        SER_NS      = 100;
  localparam logic [5:0] REF_HALF    = 6'(REF_NS / (2 * CLK_NS));
  localparam logic [5:0] MII100_HALF = 6'(MII100_NS / (2 * CLK_NS));
  localparam logic [5:0] MII10_HALF  = 6'(MII10_NS / (2 * CLK_NS));
  localparam logic [5:0] SER_HALF    = 6'(SER_NS / (2 * CLK_NS));

  localparam logic [3:0] RMII10_REPEAT      = 4'ha;
  localparam logic [3:0] FALSE_CARRIER_CODE = 4'he;
  localparam logic [3:0] SYMBOL_ERR_CODE    = 4'h5;
  localparam logic [3:0] SFD_NIBBLE         = 4'hd;
  localparam logic [1:0] SFD_LAST_DIBIT     = 2'h3;
  localparam ifc_mode_t  MODE_AT_RESET      = ifc_mii;

  // half period of the mii/serial data clocks
  function automatic logic [5:0] clk_half(input ifc_mode_t m, input logic s10);
    if (m == ifc_serial)
    begin
      return SER_HALF;
    end
    return s10 ? MII10_HALF : MII100_HALF;
  endfunction : clk_half

  // link bits carried per clock in each mode
  function automatic logic [2:0] unit_bits(input ifc_mode_t m);
    unique case (m)
      ifc_rmii:   return 3'h2;
      ifc_serial: return 3'h1;
      ifc_mii:    return 3'h4;
    endcase
  endfunction : unit_bits

endpackage : mac_phy_pkg

// ---- design/mac_phy_if.sv ----
// link wires between the phy end and the mac end
`timescale 1ns/1ns
`default_nettype none
interface mac_phy_if;
  logic       ref_clk;
  logic       tx_clk;
  logic       tx_en;
  logic [3:0] txd;
  logic       rx_clk;
  logic       rx_dv;
  logic [3:0] rxd;
  logic       rx_er;
  logic       crs;
  logic       col;

  modport phy_end
  (
    input  ref_clk, tx_clk, tx_en, txd,
    output rx_clk, rx_dv, rxd, rx_er, crs, col
  );

  modport mac_end
  (
    output ref_clk, tx_clk, tx_en, txd,
    input  rx_clk, rx_dv, rxd, rx_er, crs, col
  );
endinterface : mac_phy_if
`default_nettype wire

// ---- design/mac_end_ctrl.sv ----
// mac end of the link: makes tx clocks, sends nibbles, collects receive
`timescale 1ns/1ns
`default_nettype none
module mac_end_ctrl
  import mac_phy_pkg::*;
(
  mac_phy_if.mac_end   link,
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire ifc_mode_t  mode,
  input  wire logic       speed_10,
  input  wire logic       tx_valid,
  input  wire logic [3:0] tx_nib,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [3:0]      rx_nib,
  output logic            rx_err,
  output logic            carrier,
  output logic            collision
);

  logic       is_rmii;
  logic [5:0] refdiv_ff;
  logic       ref_clk_ff;
  logic       ref_flip;
  logic [5:0] txdiv_ff;
  logic       tx_clk_ff;
  logic       tx_flip;
  logic       fall;

  assign is_rmii  = (mode == ifc_rmii);
  assign ref_flip = (refdiv_ff >= REF_HALF - 6'h01);
  assign tx_flip  = !is_rmii && (txdiv_ff >= clk_half(mode, speed_10) - 6'h01);
  assign fall     = is_rmii ? (ref_flip && ref_clk_ff) : (tx_flip && tx_clk_ff);

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      refdiv_ff  <= 6'h00;
      ref_clk_ff <= 1'b0;
    end
    else if (ref_flip)
    begin
      refdiv_ff  <= 6'h00;
      ref_clk_ff <= !ref_clk_ff;
    end
    else
    begin
      refdiv_ff <= refdiv_ff + 6'h01;
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      txdiv_ff  <= 6'h00;
      tx_clk_ff <= 1'b0;
    end
    else if (tx_flip)
    begin
      txdiv_ff  <= 6'h00;
      tx_clk_ff <= !tx_clk_ff;
    end
    else if (!is_rmii)
    begin
      txdiv_ff <= txdiv_ff + 6'h01;
    end
  end

  // sender: data changes on the falling edge it makes
  logic [3:0] sh_ff;
  logic [2:0] left_ff;
  logic [3:0] rep_ff;
  logic       en_ff;
  logic [3:0] txd_ff;
  logic       hold;
  logic [3:0] nxt_sh;

  assign hold     = is_rmii && speed_10 && en_ff && (rep_ff != RMII10_REPEAT - 4'h1);
  assign tx_ready = fall && !hold && (left_ff <= 3'h1);
  assign nxt_sh   = is_rmii ? {2'h0, sh_ff[3:2]} : {1'b0, sh_ff[3:1]};

  function automatic logic [3:0] low_unit(input ifc_mode_t m, input logic [3:0] v);
    unique case (m)
      ifc_rmii:   return {2'h0, v[1:0]};
      ifc_serial: return {3'h0, v[0]};
      ifc_mii:    return v;
    endcase
  endfunction : low_unit

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sh_ff   <= 4'h0;
      left_ff <= 3'h0;
      rep_ff  <= 4'h0;
      en_ff   <= 1'b0;
      txd_ff  <= 4'h0;
    end
    else if (fall)
    begin
      if (hold)
      begin
        rep_ff <= rep_ff + 4'h1;
      end
      else
      begin
        rep_ff <= 4'h0;
        if (left_ff > 3'h1)
        begin
          sh_ff   <= nxt_sh;
          left_ff <= left_ff - 3'h1;
          txd_ff  <= low_unit(mode, nxt_sh);
        end
        else if (tx_valid)
        begin
          sh_ff   <= tx_nib;
          left_ff <= is_rmii ? 3'h2 : (mode == ifc_serial) ? 3'h4 : 3'h1;
          en_ff   <= 1'b1;
          txd_ff  <= low_unit(mode, tx_nib);
        end
        else
        begin
          left_ff <= 3'h0;
          en_ff   <= 1'b0;
          txd_ff  <= 4'h0;
        end
      end
    end
  end

  assign link.ref_clk = ref_clk_ff;
  assign link.tx_clk  = tx_clk_ff;
  assign link.tx_en   = en_ff;
  assign link.txd     = txd_ff;

  // receive: synchronise, sample on rising receive clock
  logic [8:0] rs1_ff;
  logic [8:0] rs2_ff;
  logic       rxc_prev_ff;
  logic       rise;
  logic [3:0] racc_ff;
  logic [1:0] rcnt_ff;
  logic       rx_valid_ff;
  logic [3:0] rx_nib_ff;
  logic       rx_err_ff;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rs1_ff      <= 9'h000;
      rs2_ff      <= 9'h000;
      rxc_prev_ff <= 1'b0;
    end
    else
    begin
      rs1_ff      <= {link.rx_clk, link.rx_dv, link.rx_er, link.crs, link.col, link.rxd};
      rs2_ff      <= rs1_ff;
      rxc_prev_ff <= rs2_ff[8];
    end
  end

  assign rise = !is_rmii && rs2_ff[8] && !rxc_prev_ff;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      racc_ff     <= 4'h0;
      rcnt_ff     <= 2'h0;
      rx_valid_ff <= 1'b0;
      rx_nib_ff   <= 4'h0;
      rx_err_ff   <= 1'b0;
    end
    else
    begin
      rx_valid_ff <= 1'b0;
      if (rise && mode == ifc_mii)
      begin
        rx_err_ff <= rs2_ff[6];
        if (rs2_ff[7])
        begin
          rx_valid_ff <= 1'b1;
          rx_nib_ff   <= rs2_ff[3:0];
        end
      end
      else if (rise)
      begin
        rx_err_ff <= 1'b0;
        if (rs2_ff[5])
        begin
          racc_ff <= {rs2_ff[0], racc_ff[3:1]};
          rcnt_ff <= rcnt_ff + 2'h1;
          if (rcnt_ff == 2'h3)
          begin
            rx_valid_ff <= 1'b1;
            rx_nib_ff   <= {rs2_ff[0], racc_ff[3:1]};
          end
        end
        else
        begin
          rcnt_ff <= 2'h0;
        end
      end
    end
  end

  assign rx_valid  = rx_valid_ff;
  assign rx_nib    = rx_nib_ff;
  assign rx_err    = rx_err_ff;
  assign carrier   = rs2_ff[5];
  assign collision = rs2_ff[4];

endmodule : mac_end_ctrl
`default_nettype wire

// ---- tb/mac_phy_chk.sv ----
// assertions on the link wires between the phy end and the mac end
`timescale 1ns/1ns
`default_nettype none
module mac_phy_chk
  import mac_phy_pkg::*;
(
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire ifc_mode_t  mode,
  input wire logic       speed_10,
  input wire logic       full_duplex,
  input wire logic       med_collision,
  input wire logic       ref_clk,
  input wire logic       tx_clk,
  input wire logic       tx_en,
  input wire logic [3:0] txd,
  input wire logic       rx_clk,
  input wire logic       rx_dv,
  input wire logic [3:0] rxd,
  input wire logic       rx_er,
  input wire logic       crs,
  input wire logic       col
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_IDLE_ZERO: assert property (mode == ifc_mii && !rx_dv && !rx_er |->
    rxd == 4'h0 || rxd == FALSE_CARRIER_CODE) else $error("rxd not zero while idle");
  AST_ER_CODE: assert property (rx_er |-> rxd == FALSE_CARRIER_CODE && !rx_dv)
    else $error("rx_er without code 1110");
  AST_ER_10M: assert property (speed_10 |-> !rx_er)
    else $error("rx_er high at 10m");
  AST_RX_SYNC: assert property ($changed(rxd) || $changed(rx_dv) |-> $fell(rx_clk))
    else $error("receive outputs moved off the rx clock");
  AST_COL: assert property ($past(rst_b) |=>
    col == $past(med_collision && !full_duplex && mode != ifc_rmii)) else $error("col wrong");
  AST_MII_CLK: assert property (mode == ifc_mii && !speed_10 && $rose(tx_clk) |->
    tx_clk[*2] ##1 !tx_clk) else $error("mii tx clock not 25 mhz");
  AST_SER_CLK: assert property (mode == ifc_serial && $rose(tx_clk) |->
    tx_clk[*5] ##1 !tx_clk) else $error("serial tx clock not 10 mhz");
  AST_REF_CLK: assert property (mode == ifc_rmii && $past(rst_b) |->
    ref_clk != $past(ref_clk)) else $error("reference clock not 50 mhz");
  AST_TX_LAUNCH: assert property ($changed(tx_en) || $changed(txd) |->
    (mode == ifc_rmii ? $fell(ref_clk) : $fell(tx_clk))) else $error("tx moved off clock");
  AST_RMII_RX_OFF: assert property (mode == ifc_rmii |->
    !rx_dv && !rx_er && !rx_clk && rxd == 4'h0) else $error("unused receive side active");
endmodule : mac_phy_chk
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench: phy end and mac end joined back to back
`timescale 1ns/1ns
`default_nettype none
module tb
  import mac_phy_pkg::*;
;
  logic       mclk, rst_b, s10, fdx, mcar, mfc, msym, mcol, prx_v, prx_r, ptx_v, p2_v;
  logic       mtx_v, mtx_r, mrx_v, mrx_e, mcarr, mcoll, plast;
  logic [3:0] prx_n, ptx_n, p2_n, mtx_n, mrx_n;
  logic [2:0] strap;
  ifc_mode_t  mode;
  ifc_mode_t  modes[6] = '{ifc_mii, ifc_mii, ifc_mii, ifc_serial, ifc_rmii, ifc_rmii};
  int         bad_count, checked, refused, lasts, t;
  int         tx_q[$], rx_q[$], got_tx[$], got_rx[$], got2[$], exp2[$];

  mac_phy_if link1();
  mac_phy_if link2();

  phy_end_ctrl #(.BUF_DEPTH(2)) phy_end_ctrl_i (.link(link1), .mclk, .rst_b,
    .cfg_mode_strap(strap), .speed_10(s10), .full_duplex(fdx), .med_carrier(mcar),
    .med_false_carrier(mfc), .med_symbol_err(msym), .med_collision(mcol), .rx_valid(prx_v),
    .rx_nib(prx_n), .rx_ready(prx_r), .tx_valid(ptx_v), .tx_nib(ptx_n), .tx_last(plast));
  phy_end_ctrl #(.BUF_DEPTH(2)) phy_end_ctrl_i2 (.link(link2), .mclk, .rst_b,
    .cfg_mode_strap(3'h1), .speed_10(s10), .full_duplex(fdx), .med_carrier(mcar),
    .med_false_carrier(mfc), .med_symbol_err(msym), .med_collision(mcol), .rx_valid(1'b0),
    .rx_nib(4'h0), .rx_ready(), .tx_valid(p2_v), .tx_nib(p2_n), .tx_last());
  mac_end_ctrl mac_end_ctrl_i (.link(link1), .mclk, .rst_b, .mode, .speed_10(s10),
    .tx_valid(mtx_v), .tx_nib(mtx_n), .tx_ready(mtx_r), .rx_valid(mrx_v), .rx_nib(mrx_n),
    .rx_err(mrx_e), .carrier(mcarr), .collision(mcoll));
  mac_phy_chk mac_phy_chk_i (.mclk, .rst_b, .mode, .speed_10(s10), .full_duplex(fdx),
    .med_collision(mcol), .ref_clk(link1.ref_clk), .tx_clk(link1.tx_clk),
    .tx_en(link1.tx_en), .txd(link1.txd), .rx_clk(link1.rx_clk), .rx_dv(link1.rx_dv),
    .rxd(link1.rxd), .rx_er(link1.rx_er), .crs(link1.crs), .col(link1.col));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // bench-made rmii transmit onto the second link, txd toggling while idle before the frame and held at 4'hf after it
  task automatic drive2(input logic [1:0] d[$], input int rep);
    @(negedge link2.ref_clk);
    repeat (4)
    begin
      link2.txd <= ~link2.txd;
      @(negedge link2.ref_clk);
    end
    foreach (d[x])
    begin
      link2.tx_en <= 1'b1;
      link2.txd   <= {2'h0, d[x]};
      repeat (rep) @(negedge link2.ref_clk);
    end
    link2.tx_en <= 1'b0;
    link2.txd   <= 4'hf;
    repeat (4) @(negedge link2.ref_clk);
  endtask : drive2

  task automatic run_mode(input ifc_mode_t m, input logic spd, input logic sym, input int n);
    logic [3:0] tv;
    logic [3:0] rv;
    int         k;
    int         k2;
    rst_b <= 1'b0;
    strap <= 3'(m);
    mode  <= m;
    s10   <= spd;
    fdx   <= 1'b0;
    mcol  <= 1'b1;
    mcar  <= (m != ifc_rmii);
    msym  <= sym;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    tx_q.delete();
    rx_q.delete();
    got_tx.delete();
    got_rx.delete();
    refused = 0;
    lasts = 0;
    repeat (8) @(posedge mclk);
    chk(8'(mcoll), 8'(m != ifc_rmii));
    if (m != ifc_rmii) chk(8'(mcarr), 8'h1);
    fdx  <= 1'b1;
    msym <= 1'b0;
    mcar <= (m == ifc_mii);
    repeat (40) @(posedge mclk);
    chk(8'(mcoll), 8'h0);
    fork
      begin
        for (int i = 0; i < n; i++)
        begin
          tv = (i < 2) ? 4'h5 : (i == 2) ? SFD_NIBBLE : 4'($urandom);
          tx_q.push_back(int'(tv));
          mtx_v <= 1'b1;
          mtx_n <= tv;
          k = 0;
          do @(negedge mclk); while (mtx_r !== 1'b1 && ++k < 3000);
          @(posedge mclk);
        end
        mtx_v <= 1'b0;
      end
      begin
        for (int j = 0; j < n && m != ifc_rmii; j++)
        begin
          rv = 4'($urandom);
          rx_q.push_back((sym && m == ifc_mii && !spd) ? int'(SYMBOL_ERR_CODE) : int'(rv));
          prx_v <= 1'b1;
          prx_n <= rv;
          k2 = 0;
          do @(negedge mclk); while (prx_r !== 1'b1 && ++k2 < 3000);
          @(posedge mclk);
        end
        prx_v <= 1'b0;
      end
    join
    repeat (400) @(posedge mclk);
    chk(8'(got_tx.size()), 8'(tx_q.size()));
    chk(8'(lasts), 8'h1);
    foreach (tx_q[x]) chk(8'(got_tx[x]), 8'(tx_q[x]));
    chk(8'(got_rx.size()), 8'(rx_q.size()));
    foreach (rx_q[x]) chk(8'(got_rx[x]), 8'(rx_q[x]));
    if (m != ifc_rmii) chk(8'(refused != 0), 8'h1);
    if (m == ifc_mii)
    begin
      mfc <= 1'b1;
      repeat (100) @(posedge mclk);
      chk(8'(mrx_e), 8'(!spd));
      chk(8'(link1.rxd), 8'(FALSE_CARRIER_CODE));
      mfc <= 1'b0;
    end
    mcar <= 1'b0;
    repeat (200) @(posedge mclk);
    chk({1'b0, link1.rx_dv, link1.crs, link1.rxd, mcarr}, 8'h0);
    if (m == ifc_rmii)
    begin
      got2.delete();
      if (spd)
      begin
        drive2('{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h1}, 10);
        exp2 = '{5, 5, 13, 10};
      end
      else
      begin
        drive2('{2'h2, 2'h1, 2'h3}, 1);
        exp2 = '{6};
      end
      repeat (100) @(posedge mclk);
      chk(8'(got2.size()), 8'(exp2.size()));
      foreach (exp2[x]) chk(8'(got2[x]), 8'(exp2[x]));
    end
  endtask : run_mode

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    link2.ref_clk = 1'b0;
    #3;
    forever #80 link2.ref_clk = ~link2.ref_clk;
  end

  // pulses stand one cycle, taken mid-cycle
  always @(negedge mclk)
  begin
    if (ptx_v === 1'b1) got_tx.push_back(int'(ptx_n));
    if (mrx_v === 1'b1) got_rx.push_back(int'(mrx_n));
    if (p2_v === 1'b1) got2.push_back(int'(p2_n));
    if (plast === 1'b1) lasts++;
    if (prx_v === 1'b1 && prx_r === 1'b0) refused++;
  end

  initial
  begin
    #400000;
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    {rst_b, s10, fdx, mcar, mfc, msym, mcol, prx_v, mtx_v} = '0;
    {prx_n, mtx_n} = '0;
    strap = 3'h2;
    mode = ifc_mii;
    link2.tx_en = 1'b0;
    link2.txd = 4'h0;
    link2.tx_clk = 1'b0;
    bad_count = 0;
    checked = 0;
    void'($urandom(32'h1dae04ba));
    for (t = 0; t < 6; t++)
    begin
      run_mode(modes[t], 1'(6'h2a >> t), 1'(6'h04 >> t), 12);
      $display("test %0d done, mode %0d", t, modes[t]);
    end
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
